// ---- core/vscp_map.svh ----
// Constants for the voice serial command port: opcodes, status bits, timing
`ifndef VSCP_MAP_SVH
`define VSCP_MAP_SVH
`define VSCP_OP_LOAD        6'b10_0101
`define VSCP_OP_PLAY        6'b10_0110
`define VSCP_OP_PU_DIRECT   6'b10_1001
`define VSCP_OP_PU_RAMPED   6'b10_1010
`define VSCP_OP_PD_DIRECT   6'b10_1101
`define VSCP_OP_PD_RAMPED   6'b10_1110
`define VSCP_OP_VOL_SET     6'b01_0001
`define VSCP_OP_VOL_DOWN    6'b01_0010
`define VSCP_OP_VOL_UP      6'b01_0101
`define VSCP_OP_PAUSE       6'b01_1001
`define VSCP_OP_RESUME      6'b01_1010
`define VSCP_OP_REWIND      6'b01_1101
`define VSCP_OP_STAT_3W     6'b01_1110
`define VSCP_OP_STAT_2W     6'b11_1111
`define VSCP_OP_HI          15
`define VSCP_OP_LO          10
`define VSCP_ST_TAG_HI      8
`define VSCP_ST_PLAYING_LOW 7
`define VSCP_ST_PENDING_LOW 6
`define VSCP_ST_VALID_LOW   2
`define VSCP_ST_PARITY      1
`define VSCP_ST_TAG_LO      0
`define VSCP_VOL_RESET      4'h0
`define VSCP_DAC_MID        16'h8000
`define VSCP_DAC_BOTTOM     16'h0000
`define VSCP_RAMP_MS        160
`define VSCP_CLK_MHZ        125
`define VSCP_RAMP_CYCLES    (`VSCP_RAMP_MS * 1000 * `VSCP_CLK_MHZ)
`endif

// ---- core/vscp_pkg.sv ----
// Types shared by the voice serial command port
package vscp_pkg;
   typedef enum logic [1:0] {
      VSCP_PWR_OFF,
      VSCP_PWR_RAMP_UP,
      VSCP_PWR_ON,
      VSCP_PWR_RAMP_DOWN
   } vscp_pwr_t;
endpackage

// ---- core/vscp_word_if.sv ----
// Carrier for words crossing from the link domain to the core domain
`timescale 1ns/1ps
`default_nettype none
interface vscp_word_if;
   logic        toggle;   // Flips once per complete command word
   logic [15:0] word;     // Held stable while toggle stands
   logic [15:0] status;   // Core status word, quasi-static
   modport link (output toggle, output word, input status);
   modport core (input toggle, input word, output status);
endinterface
`default_nettype wire

// ---- core/vscp_link.sv ----
// Serial link shifter on the serial clock: command in, status out
`timescale 1ns/1ps
`default_nettype none
module vscp_link (
   input  wire logic  i_sck,          // Serial clock pin
   input  wire logic  i_resetn,       // Async reset, active low
   input  wire logic  i_two_wire,     // 1 selects two-wire mode
   input  wire logic  i_chip_select_low, // Three-wire frame select
   input  wire logic  i_data_in,      // Serial data pin
   input  wire logic  i_start_det,    // Two-wire start seen, held high for the whole frame
   output logic       o_dout,         // Status data bit
   output logic       o_dout_oe,      // Status drive enable
   vscp_word_if.link  w               // Word carrier
);
   logic [15:0] shift_reg;
   logic [4:0]  count_reg;
   logic [15:0] stat_reg;
   logic        tog_reg;
   logic        frame;
   logic        snap_reg;
   logic        frame_rstn;

   assign frame = i_two_wire ? i_start_det : ~i_chip_select_low;
   // Clock parks outside frames, so frame end must rearm without an edge
   assign frame_rstn = i_resetn & frame;

   // Bit counter cleared as soon as the frame drops; a cut word is lost
   always_ff @(posedge i_sck or negedge frame_rstn) begin
      if (!frame_rstn) begin
         count_reg <= 5'h00;
      end else if (count_reg == 5'd15) begin
         count_reg <= 5'h00;
      end else begin
         count_reg <= count_reg + 5'd1;
      end
   end

   // Sample on rising edges, MSB first
   always_ff @(posedge i_sck or negedge i_resetn) begin
      if (!i_resetn) begin
         shift_reg <= 16'h0000;
         w.word    <= 16'h0000;
         tog_reg   <= 1'b0;
      end else if (frame) begin
         shift_reg <= {shift_reg[14:0], i_data_in};
         if (count_reg == 5'd15) begin
            w.word  <= {shift_reg[14:0], i_data_in};
            tog_reg <= ~tog_reg;
         end
      end
   end
   assign w.toggle = tog_reg;

   // Status shifts on falling edges, snapshot reloaded in every frame
   always_ff @(negedge i_sck or negedge frame_rstn) begin
      if (!frame_rstn) begin
         stat_reg <= 16'h0000;
         snap_reg <= 1'b0;
      end else if (!snap_reg) begin
         stat_reg <= w.status; // Quasi-static core word, stable mid-frame
         snap_reg <= 1'b1;
      end else begin
         stat_reg <= {stat_reg[14:0], 1'b0};
      end
   end
   assign o_dout    = stat_reg[15];
   assign o_dout_oe = frame;
endmodule
`default_nettype wire

// ---- core/vscp_top.sv ----
// Voice serial command port: decode, power, loudness and play control
`timescale 1ns/1ps
`default_nettype none
`include "vscp_map.svh"
// Contract
// - Sixteen-bit words, MSB first
// - Bits fifteen to ten select opcode
// - Load and play take ten-bit address
// - Feedback high after load until played
// - Play starts addressed group at once
// - Direct power-up jumps DAC to mid
// - Ramped power-up ramps to mid, 160 ms
// - Direct power-down forces DAC bottom
// - Ramped power-down ramps to bottom, 160 ms
// - Loudness set loads bits three to zero
// - Loudness down and up step one
// - Pause holds PWM low, freezes DAC; code freezes the DAC ramp only while a group plays
// - Rewind restarts current group
// - Two-wire data sampled on rising clock
// - Feedback high while playing or ramping
// - Loudness pins step up and down
// - Status shifted out on falling edges
// - Bits eight and zero toggle per valid command
// - Playing and pending flags, active low
// - Bit two low when command valid
// - Bit one low on odd parity
// - Status readout opcode per mode
module vscp_top
   import vscp_pkg::*;
#(
   parameter int unsigned RAMP_CYCLES = `VSCP_RAMP_CYCLES, // Ramp length in cycles
   parameter int unsigned GROUP_LEN   = 4096               // Samples per group model
) (
   input  wire logic        i_clk,              // Core clock, 125 MHz
   input  wire logic        i_resetn,           // Async reset, active low
   input  wire logic        i_sck,              // Serial clock pin
   input  wire logic        i_two_wire,         // Mode strap: 1 two-wire
   input  wire logic        i_chip_select_low,  // Three-wire select
   input  wire logic        i_data_in,          // Serial data in
   input  wire logic        i_start_det,        // Two-wire frame active
   input  wire logic        i_loudness_up_pin,  // Step loudness up
   input  wire logic        i_loudness_down_pin,// Step loudness down
   output logic             o_dout,             // Status data out
   output logic             o_dout_oe,          // Status drive enable
   output logic             o_feedback,         // Busy / load feedback
   output logic [15:0]      o_dac_current,      // DAC level
   output logic             o_pwm_a_en,         // PWM speaker a allowed
   output logic             o_pwm_b_en,         // PWM speaker b allowed
   output logic [3:0]       o_loudness,         // Loudness, 0 loudest
   output logic [9:0]       o_group_addr,       // Playing group
   output logic [15:0]      o_sample_index      // Sample within group
);
   vscp_word_if w ();

   vscp_link u_link (
      .i_sck             (i_sck),
      .i_resetn          (i_resetn),
      .i_two_wire        (i_two_wire),
      .i_chip_select_low (i_chip_select_low),
      .i_data_in         (i_data_in),
      .i_start_det       (i_start_det),
      .o_dout            (o_dout),
      .o_dout_oe         (o_dout_oe),
      .w                 (w.link)
   );

   // Word event crossing: toggle through two flops, then edge detect
   logic        tog_s1_reg, tog_s2_reg, tog_s3_reg;
   logic        cmd_pulse;
   logic [15:0] cmd_word;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         tog_s1_reg <= 1'b0;
         tog_s2_reg <= 1'b0;
         tog_s3_reg <= 1'b0;
      end else begin
         tog_s1_reg <= w.toggle;
         tog_s2_reg <= tog_s1_reg;
         tog_s3_reg <= tog_s2_reg;
      end
   end
   assign cmd_pulse = tog_s2_reg ^ tog_s3_reg;
   assign cmd_word  = w.word; // Stable for many cycles after toggle

   // Loudness pins and mode strap synchronised, rising edge steps
   logic [2:0] up_sync_reg, dn_sync_reg;
   logic [1:0] mode_sync_reg;
   logic       pin_up, pin_dn;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         up_sync_reg   <= 3'b000;
         dn_sync_reg   <= 3'b000;
         mode_sync_reg <= 2'b00;
      end else begin
         up_sync_reg   <= {up_sync_reg[1:0], i_loudness_up_pin};
         dn_sync_reg   <= {dn_sync_reg[1:0], i_loudness_down_pin};
         mode_sync_reg <= {mode_sync_reg[0], i_two_wire};
      end
   end
   assign pin_up = up_sync_reg[1] & ~up_sync_reg[2];
   assign pin_dn = dn_sync_reg[1] & ~dn_sync_reg[2];

   // Decode
   logic [5:0] op;
   logic       known, is_stat;
   assign op = cmd_word[`VSCP_OP_HI:`VSCP_OP_LO];
   assign is_stat = mode_sync_reg[1] ? (op == `VSCP_OP_STAT_2W) : (op == `VSCP_OP_STAT_3W);
   always_comb begin
      case (op)
         `VSCP_OP_LOAD, `VSCP_OP_PLAY, `VSCP_OP_PU_DIRECT, `VSCP_OP_PU_RAMPED,
         `VSCP_OP_PD_DIRECT, `VSCP_OP_PD_RAMPED, `VSCP_OP_VOL_SET, `VSCP_OP_VOL_DOWN,
         `VSCP_OP_VOL_UP, `VSCP_OP_PAUSE, `VSCP_OP_RESUME, `VSCP_OP_REWIND: known = 1'b1;
         default: known = is_stat;
      endcase
   end
   logic do_cmd;
   assign do_cmd = cmd_pulse & known;

   // Validity and toggle status
   logic tag_reg, invalid_reg;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         tag_reg     <= 1'b0;
         invalid_reg <= 1'b0;
      end else if (cmd_pulse) begin
         invalid_reg <= ~known;
         if (known) begin
            tag_reg <= ~tag_reg;
         end
      end
   end

   // Loudness: 0 loudest, "up" means louder
   logic [3:0] loud_reg;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         loud_reg <= `VSCP_VOL_RESET;
      end else if (do_cmd && op == `VSCP_OP_VOL_SET) begin
         loud_reg <= cmd_word[3:0];
      end else if ((do_cmd && op == `VSCP_OP_VOL_UP) || pin_up) begin
         if (loud_reg != 4'h0) loud_reg <= loud_reg - 4'h1;
      end else if ((do_cmd && op == `VSCP_OP_VOL_DOWN) || pin_dn) begin
         if (loud_reg != 4'hF) loud_reg <= loud_reg + 4'h1;
      end
   end
   assign o_loudness = loud_reg;

   // Play control: pending slot and current group
   logic        pending_reg, playing_reg, paused_reg;
   logic [9:0]  pend_addr_reg, cur_addr_reg;
   logic [15:0] idx_reg;
   logic        group_done;
   assign group_done = playing_reg && !paused_reg && (idx_reg == 16'(GROUP_LEN - 1));
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pending_reg   <= 1'b0;
         pend_addr_reg <= 10'h000;
      end else if (do_cmd && op == `VSCP_OP_LOAD) begin
         pending_reg   <= 1'b1;
         pend_addr_reg <= cmd_word[9:0];
      end else if (pending_reg && (!playing_reg || group_done)) begin
         pending_reg   <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         playing_reg  <= 1'b0;
         paused_reg   <= 1'b0;
         cur_addr_reg <= 10'h000;
         idx_reg      <= 16'h0000;
      end else if (do_cmd && op == `VSCP_OP_PLAY) begin
         playing_reg  <= 1'b1;
         paused_reg   <= 1'b0;
         cur_addr_reg <= cmd_word[9:0];
         idx_reg      <= 16'h0000;
      end else if (do_cmd && op == `VSCP_OP_REWIND) begin
         idx_reg      <= 16'h0000;
         playing_reg  <= 1'b1;
      end else if (do_cmd && op == `VSCP_OP_PAUSE) begin
         paused_reg   <= 1'b1;
      end else if (do_cmd && op == `VSCP_OP_RESUME) begin
         paused_reg   <= 1'b0;
      end else if (pending_reg && (!playing_reg || group_done)) begin
         playing_reg  <= 1'b1;
         cur_addr_reg <= pend_addr_reg;
         idx_reg      <= 16'h0000;
      end else if (group_done) begin
         playing_reg  <= 1'b0;
      end else if (playing_reg && !paused_reg) begin
         idx_reg      <= idx_reg + 16'h0001;
      end
   end
   assign o_group_addr   = cur_addr_reg;
   assign o_sample_index = idx_reg;
   assign o_pwm_a_en     = playing_reg & ~paused_reg;
   assign o_pwm_b_en     = playing_reg & ~paused_reg;

   // Power and DAC level with linear ramps
   vscp_pwr_t   pwr_reg;
   logic [15:0] dac_reg;
   logic [31:0] ramp_cnt_reg;
   logic [31:0] ramp_pos;
   assign ramp_pos = ramp_cnt_reg + 32'd1;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pwr_reg      <= VSCP_PWR_OFF;
         dac_reg      <= `VSCP_DAC_BOTTOM;
         ramp_cnt_reg <= 32'h0000_0000;
      end else if (do_cmd && op == `VSCP_OP_PU_DIRECT) begin
         pwr_reg <= VSCP_PWR_ON;
         dac_reg <= `VSCP_DAC_MID;
      end else if (do_cmd && op == `VSCP_OP_PU_RAMPED) begin
         pwr_reg      <= VSCP_PWR_RAMP_UP;
         dac_reg      <= `VSCP_DAC_BOTTOM;
         ramp_cnt_reg <= 32'h0000_0000;
      end else if (do_cmd && op == `VSCP_OP_PD_DIRECT) begin
         pwr_reg <= VSCP_PWR_OFF;
         dac_reg <= `VSCP_DAC_BOTTOM;
      end else if (do_cmd && op == `VSCP_OP_PD_RAMPED) begin
         pwr_reg      <= VSCP_PWR_RAMP_DOWN;
         ramp_cnt_reg <= 32'h0000_0000;
      end else if (!(paused_reg && playing_reg)) begin
         case (pwr_reg)
            VSCP_PWR_RAMP_UP: begin
               ramp_cnt_reg <= ramp_pos;
               dac_reg <= 16'((64'(ramp_pos) * 64'(`VSCP_DAC_MID)) / 64'(RAMP_CYCLES));
               if (ramp_pos >= RAMP_CYCLES) begin
                  pwr_reg <= VSCP_PWR_ON;
                  dac_reg <= `VSCP_DAC_MID;
               end
            end
            VSCP_PWR_RAMP_DOWN: begin
               ramp_cnt_reg <= ramp_pos;
               // Step down proportionally from wherever the level stood
               if (ramp_pos >= RAMP_CYCLES || dac_reg == `VSCP_DAC_BOTTOM) begin
                  pwr_reg <= VSCP_PWR_OFF;
                  dac_reg <= `VSCP_DAC_BOTTOM;
               end else begin
                  dac_reg <= dac_reg - 16'(32'(dac_reg) / (RAMP_CYCLES - ramp_cnt_reg));
               end
            end
            default: ;
         endcase
      end
   end
   assign o_dac_current = dac_reg;

   // Feedback: busy while playing or ramping, or a load waits
   assign o_feedback = playing_reg | pending_reg | (pwr_reg == VSCP_PWR_RAMP_UP) |
                       (pwr_reg == VSCP_PWR_RAMP_DOWN);

   // Status word for readout
   always_comb begin
      w.status = 16'h0000;
      w.status[`VSCP_ST_TAG_HI]      = tag_reg;
      w.status[`VSCP_ST_PLAYING_LOW] = ~playing_reg;
      w.status[`VSCP_ST_PENDING_LOW] = ~pending_reg;
      w.status[`VSCP_ST_VALID_LOW]   = invalid_reg;
      w.status[`VSCP_ST_PARITY]      = ~(^pend_addr_reg);
      w.status[`VSCP_ST_TAG_LO]      = tag_reg;
   end
endmodule
`default_nettype wire

// ---- tb/vscp_host_model.sv ----
// Host model that drives the serial command pins
`timescale 1ns/1ps
`default_nettype none
module vscp_host_model (
   input  wire logic i_two_wire,        // Mode in use
   input  wire logic i_dout,            // Status bit from device
   output var logic  o_sck,             // Serial clock
   output var logic  o_chip_select_low, // Three-wire select
   output var logic  o_data,            // Serial data
   output var logic  o_start_det        // Two-wire frame active
);
   // Idle: clock parked low, no frame
   initial begin
      o_sck = 1'b0;
      o_chip_select_low = 1'b1;
      o_data = 1'b0;
      o_start_det = 1'b0;
   end
   // One whole word at 6 ns per bit; clock stands still outside frames
   task automatic xfer(input logic [15:0] w, output logic [15:0] st);
      if (i_two_wire) o_start_det = 1'b1;
      else o_chip_select_low = 1'b0;
      #6;
      for (int i = 15; i >= 0; i--) begin
         o_data = w[i];
         #2 o_sck = 1'b1;
         #3 o_sck = 1'b0;
         #1 st = {st[14:0], i_dout};
      end
      o_chip_select_low = 1'b1;
      o_start_det = 1'b0;
      o_data = ~o_data; // Released line must not look held
   endtask
endmodule
`default_nettype wire

// ---- tb/vscp_top_properties.sv ----
// Pin-level assertions for the voice serial command port
`timescale 1ns/1ps
`default_nettype none
module vscp_top_properties #(
   parameter int unsigned GROUP_LEN = 4096 // Samples per group
) (
   input wire logic        i_clk,             // Core clock
   input wire logic        i_resetn,          // Reset, low
   input wire logic        i_two_wire,        // Mode
   input wire logic        i_chip_select_low, // Select
   input wire logic        i_start_det,       // Two-wire frame
   input wire logic        o_dout_oe,         // Status enable
   input wire logic        o_feedback,        // Busy
   input wire logic [15:0] o_dac_current,     // DAC level
   input wire logic        o_pwm_a_en,        // PWM a
   input wire logic        o_pwm_b_en,        // PWM b
   input wire logic [3:0]  o_loudness,        // Loudness
   input wire logic [9:0]  o_group_addr,      // Group
   input wire logic [15:0] o_sample_index     // Sample
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   wire frame = i_two_wire ? i_start_det : !i_chip_select_low;
   // Quiet count; words land within four cycles, so later moves are pin steps
   logic [3:0] quiet_reg;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) quiet_reg <= 4'h0;
      else if (frame) quiet_reg <= 4'h0;
      else if (quiet_reg != 4'hF) quiet_reg <= quiet_reg + 4'h1;
   end
   oe_frame_a: assert property (o_dout_oe == frame)
      else $error("status drive outside frame");
   pwm_pair_a: assert property (o_pwm_a_en == o_pwm_b_en)
      else $error("speaker enables differ");
   pwm_busy_a: assert property (o_pwm_a_en |-> o_feedback)
      else $error("sound without busy");
   ramp_busy_a: assert property ($changed(o_dac_current) && o_dac_current != 16'h8000
      && o_dac_current != 16'h0000 && !o_pwm_a_en |-> o_feedback) else $error("ramp without busy");
   ramp_range_a: assert property ($changed(o_dac_current) && !o_pwm_a_en && !$past(o_pwm_a_en)
      |-> o_dac_current <= 16'h8000) else $error("ramp above mid");
   index_bound_a: assert property (o_sample_index < GROUP_LEN)
      else $error("sample index past group");
   group_start_a: assert property ($changed(o_group_addr) |-> ##[0:2] o_sample_index <= 16'h0001)
      else $error("new group not at start");
   loud_step_a: assert property (quiet_reg == 4'hF && $changed(o_loudness)
      |-> 4'(o_loudness - $past(o_loudness)) inside {4'h1, 4'hF}) else $error("loudness jump");
   cover property ($rose(o_feedback));
   cover property ($rose(o_dac_current == 16'h8000));
   cover property ($fell(o_pwm_a_en) && o_feedback);
endmodule
bind vscp_top vscp_top_properties #(.GROUP_LEN(GROUP_LEN)) props (.i_clk(i_clk), .i_resetn(i_resetn),
   .i_two_wire(i_two_wire), .i_chip_select_low(i_chip_select_low), .i_start_det(i_start_det),
   .o_dout_oe(o_dout_oe), .o_feedback(o_feedback), .o_dac_current(o_dac_current), .o_pwm_a_en(o_pwm_a_en),
   .o_pwm_b_en(o_pwm_b_en), .o_loudness(o_loudness), .o_group_addr(o_group_addr),
   .o_sample_index(o_sample_index));
`default_nettype wire

// ---- tb/vscp_top_tb.sv ----
// Self-checking bench for the voice serial command port
`timescale 1ns/1ps
`default_nettype none
`include "vscp_map.svh"
module vscp_top_tb;
   logic             i_clk, i_resetn, i_two_wire, up_pin, down_pin;
   wire logic        sck, csl, sdi, start, dout, dout_oe, fb, pwm_a, pwm_b;
   wire logic [15:0] dac, idx;
   wire logic [3:0]  loud;
   wire logic [9:0]  grp;
   logic [15:0]      st, prev_st, held, held_idx;
   int               bad_count = 0, comparisons = 0, n_valid = 0, prev_n = -1, cyc = 0, n;
   vscp_top #(.RAMP_CYCLES(100), .GROUP_LEN(512)) dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_sck(sck),
      .i_two_wire(i_two_wire), .i_chip_select_low(csl), .i_data_in(sdi), .i_start_det(start),
      .i_loudness_up_pin(up_pin), .i_loudness_down_pin(down_pin), .o_dout(dout), .o_dout_oe(dout_oe),
      .o_feedback(fb), .o_dac_current(dac), .o_pwm_a_en(pwm_a), .o_pwm_b_en(pwm_b), .o_loudness(loud),
      .o_group_addr(grp), .o_sample_index(idx));
   vscp_host_model host (.i_two_wire(i_two_wire), .i_dout(dout), .o_sck(sck), .o_chip_select_low(csl),
      .o_data(sdi), .o_start_det(start));
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   // Hang guard, well above the expected run
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 60000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   // Whole word, then room for the 3-4 cycle apply latency
   task automatic cmd(input logic [5:0] op, input logic [9:0] arg, input bit ok);
      @(posedge i_clk);
      #1 host.xfer({op, arg}, st);
      n_valid += ok;
      repeat (10) @(posedge i_clk);
      #1;
   endtask
   // Readout; tag must have flipped once per valid word since last snapshot
   task automatic rd_status();
      cmd(i_two_wire ? `VSCP_OP_STAT_2W : `VSCP_OP_STAT_3W, 10'h000, 1'b1);
      check(st[8], st[0], "tag copies differ");
      if (prev_n >= 0) check(st[8], prev_st[8] ^ n_valid[0] ^ prev_n[0] ^ 1'b1, "tag count");
      prev_st = st;
      prev_n = n_valid - 1;
   endtask
   task automatic wait_dac(input logic [15:0] v);
      for (n = 0; n < 200 && dac !== v; n++) begin
         @(posedge i_clk);
         #1;
      end
   endtask
   task automatic step(input bit up);
      if (up) up_pin = 1'b1;
      else down_pin = 1'b1;
      repeat (6) @(posedge i_clk);
      #1 up_pin = 1'b0;
      down_pin = 1'b0;
      repeat (8) @(posedge i_clk);
      #1;
   endtask
   task automatic t_ramp();
      cmd(`VSCP_OP_PU_RAMPED, 10'h000, 1'b1);
      check(fb, 1'b1, "busy in ramp");
      check(dac < 16'h8000, 1'b1, "ramp up jumped");
      wait_dac(16'h8000);
      check(dac, 16'h8000, "ramp up end");
      cmd(`VSCP_OP_PD_RAMPED, 10'h000, 1'b1);
      check(dac > 16'h0000, 1'b1, "ramp down jumped");
      wait_dac(16'h0000);
      check(dac, 16'h0000, "ramp down end");
      $display("ramp test done");
   endtask
   task automatic t_loud();
      cmd(`VSCP_OP_PU_DIRECT, 10'h000, 1'b1);
      check(dac, 16'h8000, "direct up");
      cmd(`VSCP_OP_VOL_SET, 10'h009, 1'b1);
      check(loud, 4'h9, "loudness set");
      cmd(`VSCP_OP_VOL_DOWN, 10'h3F0, 1'b1);
      check(loud, 4'hA, "loudness down");
      cmd(`VSCP_OP_VOL_UP, 10'h000, 1'b1);
      check(loud, 4'h9, "loudness up");
      step(1'b1);
      check(loud, 4'h8, "up pin");
      step(1'b0);
      check(loud, 4'h9, "down pin");
      $display("loudness test done");
   endtask
   task automatic t_load();
      rd_status();
      cmd(`VSCP_OP_LOAD, 10'h155, 1'b1);
      check(fb, 1'b1, "load feedback");
      check(grp, 10'h155, "load address");
      rd_status();
      check(st[2:1], 2'b00, "valid, odd parity");
      check(st[7], 1'b0, "playing flag");
      for (n = 0; n < 30000 && fb !== 1'b0; n++) begin
         @(posedge i_clk);
         #1;
      end
      check(fb, 1'b0, "load released");
      rd_status();
      check(st[7:6], 2'b11, "idle flags");
      cmd(6'h00, 10'h000, 1'b0);
      rd_status();
      check(st[2], 1'b1, "invalid flagged");
      check(grp, 10'h155, "invalid kept group");
      $display("load and status test done");
   endtask
   task automatic t_play();
      cmd(`VSCP_OP_PLAY, 10'h3C0, 1'b1);
      check(grp, 10'h3C0, "play address");
      check(pwm_a & fb, 1'b1, "play at once");
      cmd(`VSCP_OP_PAUSE, 10'h000, 1'b1);
      check({pwm_a, pwm_b}, 2'b00, "pause outputs");
      held = dac;
      held_idx = idx;
      repeat (20) @(posedge i_clk);
      #1;
      check(dac, held, "pause freeze");
      check(idx, held_idx, "pause index freeze");
      cmd(`VSCP_OP_RESUME, 10'h000, 1'b1);
      check(pwm_a, 1'b1, "resume");
      cmd(`VSCP_OP_REWIND, 10'h000, 1'b1);
      check(idx < 16'h0010 && grp === 10'h3C0, 1'b1, "rewind start");
      // A load while a group plays must wait its turn
      cmd(`VSCP_OP_LOAD, 10'h2A8, 1'b1);
      check(grp, 10'h3C0, "load waits");
      rd_status();
      check(st[7:6], 2'b00, "group queued");
      check(st[1], 1'b1, "even parity");
      $display("play test done");
   endtask
   task automatic t_two();
      i_two_wire = 1'b1;
      cmd(`VSCP_OP_VOL_SET, 10'h005, 1'b1);
      check(loud, 4'h5, "two-wire set");
      rd_status();
      check(st[2], 1'b0, "two-wire readout");
      cmd(`VSCP_OP_PD_DIRECT, 10'h000, 1'b1);
      check(dac, 16'h0000, "direct down");
      $display("two-wire test done");
   endtask
   initial begin
      i_resetn = 1'b0;
      i_two_wire = 1'b0;
      up_pin = 1'b0;
      down_pin = 1'b0;
      repeat (2) @(posedge i_clk);
      #1 i_resetn = 1'b1;
      repeat (2) @(posedge i_clk);
      t_ramp();
      t_loud();
      t_load();
      t_play();
      t_two();
      tally_and_finish();
   end
endmodule
`default_nettype wire
